// ===== verilog/serial_cfg_pkg.sv
// Constants shared by both ends of the three-wire configuration port.
// Assumes both ends run on one fast system clock and see the link as pins.
`default_nettype none
package serial_cfg_pkg;
  // ****************************************
  // Framing
  // ****************************************
  localparam int INSTR_BITS = 16; // Instruction phase length
  localparam int BYTE_BITS = 8; // Data unit
  localparam int ADDR_W = 15; // Register address width
  localparam int RW_BIT = 15; // Direction bit inside instruction
  localparam logic RW_READ = 1'b1; // Direction code for a read
  localparam logic [3:0] INSTR_LAST = 4'hF; // Last instruction bit index
  localparam logic [3:0] BYTE_LAST = 4'h7; // Last data bit index
  // ****************************************
  // Register map
  // ****************************************
  localparam int REG_COUNT = 32; // Implemented byte registers
  localparam int IDX_W = $clog2(REG_COUNT);
  localparam logic [7:0] REG_RESET = 8'h00; // Reset value of all registers
  localparam logic [ADDR_W-1:0] CFG_ADDR = 15'h0000; // Port configuration
  localparam int LSB_FIRST_BIT = 6; // Bit order select in CFG_ADDR
  localparam logic [ADDR_W-1:0] TUNING_ADDR = 15'h0010; // Tuning word, low byte
  localparam int TUNING_BYTES = 4;
  localparam logic [ADDR_W-1:0] PHASE_ADDR = 15'h0014; // Phase offset, low byte
  localparam int PHASE_BYTES = 2;
  localparam int HELD_BYTES = TUNING_BYTES + PHASE_BYTES; // Held until update
  localparam logic [ADDR_W-1:0] UPDATE_ADDR = 15'h0016; // Tuning update control
  localparam int UPDATE_BIT = 0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00; // Read value off the map
  // ****************************************
  // Timing
  // ****************************************
  localparam int MCLK_MHZ = 250; // System clock rate
  localparam int SCLK_MAX_MHZ = 40; // Fastest allowed serial clock
  localparam int HALF_MIN = (MCLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam int HALF_DEFAULT = 10; // Half period in mclk cycles, 80 ns sclk
  // ****************************************
  // Host and device sequencer states
  // ****************************************
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_STOP} host_state_t;
  typedef enum logic [1:0] {D_IDLE, D_INSTR, D_DATA} dev_state_t;
endpackage : serial_cfg_pkg
`default_nettype wire

// ===== verilog/serial_cfg_if.sv
// Three-wire link between the serial master and the configuration port.
// Assumes the bench joins both modports; the shared data wire idles high.
`default_nettype none
interface serial_cfg_if;
  logic cs_n; // Select, active low, from host
  logic sclk; // Serial clock, from host
  logic host_sdio_o; // Host data drive
  logic host_sdio_oe; // Host drives the data wire
  logic dev_sdio_o; // Device data drive
  logic dev_sdio_oe; // Device drives the data wire
  logic sdio; // Resolved wire level
  // Wire level from the enables, weak pull-up when nobody drives
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
  modport host (output cs_n, output sclk, output host_sdio_o, output host_sdio_oe, input sdio);
  modport device (input cs_n, input sclk, input sdio, output dev_sdio_o, output dev_sdio_oe);
endinterface : serial_cfg_if
`default_nettype wire

// ===== verilog/serial_cfg_device.sv
// Configuration port end: serial sequencer and its byte register file.
// Assumes link pins are asynchronous to mclk_i; sclk is far slower than mclk_i.
`default_nettype none
module serial_cfg_device
  import serial_cfg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  serial_cfg_if.device link,
  output logic lsb_first_o,
  output logic [8*TUNING_BYTES-1:0] freq_tuning_word_o,
  output logic [8*PHASE_BYTES-1:0] phase_offset_o,
  output logic busy_o
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic cs_s1_q, cs_s2_q; // Select sync pair
  logic sck_s1_q, sck_s2_q, sck_d_q; // Clock sync pair and edge history
  logic sd_s1_q, sd_s2_q; // Data sync pair

  // Two flops per pin before any logic looks at it
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_d_q <= 1'b0;
      sd_s1_q <= 1'b1;
      sd_s2_q <= 1'b1;
    end else if (ce_i) begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      sck_s1_q <= link.sclk;
      sck_s2_q <= sck_s1_q;
      sck_d_q <= sck_s2_q;
      sd_s1_q <= link.sdio;
      sd_s2_q <= sd_s1_q;
    end
  end

  // ****************************************
  // Sequencer state
  // ****************************************
  dev_state_t state_q; // Phase of the cycle
  logic [3:0] bit_q; // Bit index in instruction or byte
  logic [INSTR_BITS-1:0] sr_q; // Receive shifter
  logic rw_q; // Direction of this cycle
  logic [ADDR_W-1:0] addr_q; // Current register address
  logic [7:0] tx_q; // Read byte being shifted out
  logic out_q, oe_q; // Data pin drive and enable
  logic [7:0] regs_q [REG_COUNT]; // Active register bytes
  logic [7:0] held_q [HELD_BYTES]; // Pending tuning and phase bytes

  // Edge and mode decode
  wire sck_rise = sck_s2_q & ~sck_d_q;
  wire sck_fall = ~sck_s2_q & sck_d_q;
  wire selected = ~cs_s2_q;
  wire lsb_first = regs_q[CFG_ADDR[IDX_W-1:0]][LSB_FIRST_BIT];

  // Next shifter value, order set by the mode bit
  wire [INSTR_BITS-1:0] instr_nx = lsb_first ? {sd_s2_q, sr_q[INSTR_BITS-1:1]}
                                             : {sr_q[INSTR_BITS-2:0], sd_s2_q};
  wire [7:0] byte_nx = lsb_first ? {sd_s2_q, sr_q[7:1]} : {sr_q[6:0], sd_s2_q};
  wire instr_done = (state_q == D_INSTR) && sck_rise && (bit_q == INSTR_LAST);
  wire byte_done = (state_q == D_DATA) && sck_rise && (bit_q == BYTE_LAST);

  // Address of the next byte in a multibyte cycle
  wire [ADDR_W-1:0] addr_step = lsb_first ? addr_q + 15'h0001 : addr_q - 15'h0001;

  // Read address: start address right after the instruction, then stepped
  wire [ADDR_W-1:0] rd_addr = (state_q == D_INSTR) ? instr_nx[ADDR_W-1:0] : addr_step;
  wire rd_mapped = rd_addr < ADDR_W'(REG_COUNT);
  wire [7:0] rd_byte = rd_mapped ? regs_q[rd_addr[IDX_W-1:0]] : UNMAPPED_READ;

  // Write decode for the byte just completed
  wire do_write = byte_done && (rw_q != RW_READ);
  wire wr_update = (addr_q == UPDATE_ADDR) && byte_nx[UPDATE_BIT];
  wire wr_held = (addr_q >= TUNING_ADDR) && (addr_q < TUNING_ADDR + ADDR_W'(HELD_BYTES));
  wire [ADDR_W-1:0] held_off = addr_q - TUNING_ADDR;
  wire wr_mapped = addr_q < ADDR_W'(REG_COUNT);
  wire load_tx = (instr_done && instr_nx[RW_BIT] == RW_READ) || (byte_done && rw_q == RW_READ);

  // ****************************************
  // Cycle sequencer
  // ****************************************
  // Select high parks the sequencer ready for a fresh instruction
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_q <= D_IDLE;
      bit_q <= 4'h0;
      sr_q <= '0;
      rw_q <= 1'b0;
      addr_q <= '0;
    end else if (ce_i) begin
      if (!selected) begin
        state_q <= D_IDLE;
        bit_q <= 4'h0;
      end else begin
        case (state_q)
          D_IDLE: begin
            state_q <= D_INSTR;
            bit_q <= 4'h0;
          end
          D_INSTR: begin
            if (sck_rise) begin
              sr_q <= instr_nx;
              bit_q <= bit_q + 4'h1;
              if (instr_done) begin
                state_q <= D_DATA;
                rw_q <= instr_nx[RW_BIT];
                addr_q <= instr_nx[ADDR_W-1:0];
                bit_q <= 4'h0;
              end
            end
          end
          D_DATA: begin
            if (sck_rise) begin
              sr_q <= {sr_q[INSTR_BITS-1:8], byte_nx};
              bit_q <= bit_q + 4'h1;
              if (byte_done) begin
                addr_q <= addr_step;
                bit_q <= 4'h0;
              end
            end
          end
          default: state_q <= D_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Read data driver
  // ****************************************
  // Byte loaded on the rising edge, bits launched on falling edges
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      tx_q <= 8'h00;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (ce_i) begin
      if (!selected) begin
        oe_q <= 1'b0;
      end else if (load_tx) begin
        tx_q <= rd_byte;
      end else if (sck_fall && state_q == D_DATA && rw_q == RW_READ) begin
        out_q <= lsb_first ? tx_q[0] : tx_q[7];
        tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        oe_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  // Plain bytes land at the last bit; tuning and phase bytes wait for the update bit
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET;
      end
      for (int i = 0; i < HELD_BYTES; i++) begin
        held_q[i] <= REG_RESET;
      end
    end else if (ce_i && do_write) begin
      if (addr_q == UPDATE_ADDR) begin
        if (wr_update) begin
          for (int i = 0; i < HELD_BYTES; i++) begin
            regs_q[IDX_W'(TUNING_ADDR) + IDX_W'(i)] <= held_q[i];
          end
        end
        regs_q[UPDATE_ADDR[IDX_W-1:0]] <= byte_nx & ~(8'h01 << UPDATE_BIT); // Self-clearing
      end else if (wr_held) begin
        held_q[held_off[$clog2(HELD_BYTES)-1:0]] <= byte_nx;
      end else if (wr_mapped) begin
        regs_q[addr_q[IDX_W-1:0]] <= byte_nx;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Tuning word and phase offset, low byte at the lower address
  for (genvar g = 0; g < TUNING_BYTES; g++) begin : g_tuning
    assign freq_tuning_word_o[8*g +: 8] = regs_q[IDX_W'(TUNING_ADDR) + IDX_W'(g)];
  end
  for (genvar g = 0; g < PHASE_BYTES; g++) begin : g_phase
    assign phase_offset_o[8*g +: 8] = regs_q[IDX_W'(PHASE_ADDR) + IDX_W'(g)];
  end
  assign lsb_first_o = lsb_first;
  assign busy_o = (state_q != D_IDLE);
  assign link.dev_sdio_o = out_q;
  assign link.dev_sdio_oe = oe_q;
endmodule : serial_cfg_device
`default_nettype wire

// ===== verilog/serial_cfg_host.sv
// Serial master end: frames instruction and data bytes onto the link.
// Assumes the user keeps the bit order equal to the device's mode bit.
`default_nettype none
module serial_cfg_host
  import serial_cfg_pkg::*;
#(
  parameter int HALF = HALF_DEFAULT, // Sclk half period in mclk cycles
  parameter int LEN_W = 4 // Byte count width, count minus one
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  serial_cfg_if.host link,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_read_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [LEN_W-1:0] req_len_i,
  input wire logic lsb_first_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_take_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o
);
  // ****************************************
  // State
  // ****************************************
  localparam int HALF_USE = (HALF < HALF_MIN) ? HALF_MIN : HALF;
  localparam int CNT_W = LEN_W + 5; // Wide enough for all bits
  host_state_t state_q;
  logic [$clog2(HALF_USE+1)-1:0] div_q; // Half period divider
  logic sclk_q, cs_n_q, out_q, oe_q;
  logic [CNT_W-1:0] rises_q, total_q; // Rising edges done and due
  logic [INSTR_BITS-1:0] tx_q; // Outgoing word, current bit at the edge
  logic [7:0] rx_q; // Read byte assembly
  logic rd_q, lsb_q, take_q, rdv_q;
  logic [7:0] rd_data_q;
  logic sd_s1_q, sd_s2_q; // Data wire sync pair

  wire tick = (div_q == '0);
  wire in_data = rises_q >= CNT_W'(INSTR_BITS);
  wire at_byte = in_data && (rises_q[2:0] == 3'h0); // Byte boundary count
  wire [INSTR_BITS-1:0] shifted = lsb_q ? (tx_q >> 1) : (tx_q << 1);
  wire [INSTR_BITS-1:0] loaded = lsb_q ? {8'h00, wr_data_i} : {wr_data_i, 8'h00};
  wire [INSTR_BITS-1:0] next_w = (at_byte && !rd_q) ? loaded : shifted;
  wire [7:0] rx_nx = lsb_q ? {sd_s2_q, rx_q[7:1]} : {rx_q[6:0], sd_s2_q};
  wire [CNT_W-1:0] rises_nx = rises_q + CNT_W'(1);
  wire rx_bit = rd_q && in_data; // Reading this rising edge

  // Data wire sync
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sd_s1_q <= 1'b1;
      sd_s2_q <= 1'b1;
    end else if (ce_i) begin
      sd_s1_q <= link.sdio;
      sd_s2_q <= sd_s1_q;
    end
  end

  // ****************************************
  // Frame sequencer
  // ****************************************
  // Drives on falling edges, samples on rising edges
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_q <= H_IDLE;
      div_q <= '0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      out_q <= 1'b0;
      oe_q <= 1'b0;
      rises_q <= '0;
      total_q <= '0;
      tx_q <= '0;
      rx_q <= 8'h00;
      rd_q <= 1'b0;
      lsb_q <= 1'b0;
      take_q <= 1'b0;
      rdv_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (ce_i) begin
      take_q <= 1'b0;
      rdv_q <= 1'b0;
      div_q <= tick ? $bits(div_q)'(HALF_USE - 1) : div_q - 1'b1;
      case (state_q)
        H_IDLE: begin
          div_q <= $bits(div_q)'(HALF_USE - 1);
          if (req_valid_i) begin
            state_q <= H_RUN;
            cs_n_q <= 1'b0;
            rd_q <= req_read_i;
            lsb_q <= lsb_first_i;
            tx_q <= {req_read_i, req_addr_i};
            out_q <= lsb_first_i ? req_addr_i[0] : req_read_i;
            oe_q <= 1'b1;
            rises_q <= '0;
            total_q <= CNT_W'(INSTR_BITS) + CNT_W'(BYTE_BITS) * (CNT_W'(req_len_i) + CNT_W'(1));
          end
        end
        H_RUN: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
            rises_q <= rises_nx;
            if (rx_bit) begin
              rx_q <= rx_nx;
              if (rises_nx[2:0] == 3'h0) begin
                rd_data_q <= rx_nx;
                rdv_q <= 1'b1;
              end
            end
          end else if (tick) begin
            sclk_q <= 1'b0;
            if (rises_q == total_q) begin
              state_q <= H_STOP;
              oe_q <= 1'b0;
            end else begin
              tx_q <= next_w;
              out_q <= lsb_q ? next_w[0] : next_w[INSTR_BITS-1];
              take_q <= at_byte && !rd_q;
              oe_q <= !(rd_q && in_data);
            end
          end
        end
        H_STOP: begin
          if (tick) begin
            if (!cs_n_q) begin
              cs_n_q <= 1'b1;
            end else begin
              state_q <= H_IDLE;
            end
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign req_ready_o = (state_q == H_IDLE);
  assign wr_take_o = take_q;
  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rdv_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.host_sdio_o = out_q;
  assign link.host_sdio_oe = oe_q;
endmodule : serial_cfg_host
`default_nettype wire

// ===== test/serial_cfg_properties.sv
// Checker for the three-wire link between the host end and the device end.
// Assumes the bench instantiates it beside the link interface, all in the mclk_i domain.
`default_nettype none
module serial_cfg_properties (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helper count
  // ****************************************
  logic [7:0] rises_q; // Serial rises since select fell
  // Count serial rises inside a frame, clear while select is high
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || cs_n) begin
      rises_q <= 8'h00;
    end else begin
      rises_q <= rises_q + {7'h00, $rose(sclk)};
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // ****************************************
  // Link properties
  // ****************************************
  a_pin_released: assert property (cs_n [*6] |-> !dev_sdio_oe)
    else $error("device drives data while deselected");
  a_single_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data wire");
  a_host_idle: assert property (cs_n |-> !host_sdio_oe && !sclk)
    else $error("host active outside a frame");
  a_sclk_high: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high phase too short");
  a_sclk_low: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("serial clock low phase too short");
  a_host_launch: assert property (host_sdio_oe && $changed(host_sdio_o) |-> !sclk)
    else $error("host data changed while clock high");
  a_dev_launch: assert property (dev_sdio_oe && $changed(dev_sdio_o) |-> !sclk)
    else $error("device data changed while clock high");
  a_whole_bytes: assert property ($rose(cs_n) |-> rises_q >= 8'h18 && rises_q[2:0] == 3'h0)
    else $error("frame not instruction plus whole bytes");
  a_read_turn: assert property ($rose(dev_sdio_oe) |-> rises_q == 8'h10 && !host_sdio_oe)
    else $error("device drive began at wrong point");
endmodule : serial_cfg_properties
`default_nettype wire

// ===== test/three_wire_serial_config_port_tb.sv
// Bench joining host and device ends over the link, driving the host user port.
// Assumes the package, interface and both design ends are compiled first.
`default_nettype none
module three_wire_serial_config_port_tb;
  import serial_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic req_valid = 1'h0; // Host request and its qualifiers
  logic req_ready;
  logic req_read = 1'h0;
  logic [ADDR_W-1:0] req_addr = 15'h0000;
  logic [3:0] req_len = 4'h0;
  logic lsb_mode = 1'h0; // Bit order the host frames with
  logic [7:0] wr_data = 8'h00;
  logic wr_take;
  logic [7:0] rd_data;
  logic rd_valid;
  logic lsb_first;
  logic [31:0] tuning_word;
  logic ce = 1'h1; // Clock enable shared by both ends
  logic ce_seen = 1'h1; // Enable as the last rising edge saw it
  logic [15:0] phase;
  logic busy;
  logic [15:0] instr_seen = 16'h0000; // Instruction taken off the wire
  logic sclk_d = 1'h0;
  int bits = 0;
  logic [7:0] wb [16]; // Bytes to send, then bytes received
  logic [7:0] rb [16];
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  serial_cfg_if link ();
  serial_cfg_host u_serial_cfg_host (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce),
    .link(link),
    .req_valid_i(req_valid),
    .req_ready_o(req_ready),
    .req_read_i(req_read),
    .req_addr_i(req_addr),
    .req_len_i(req_len),
    .lsb_first_i(lsb_mode),
    .wr_data_i(wr_data),
    .wr_take_o(wr_take),
    .rd_data_o(rd_data),
    .rd_valid_o(rd_valid)
  );
  serial_cfg_device u_serial_cfg_device (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce),
    .link(link),
    .lsb_first_o(lsb_first),
    .freq_tuning_word_o(tuning_word),
    .phase_offset_o(phase),
    .busy_o(busy)
  );
  serial_cfg_properties u_serial_cfg_properties (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .cs_n(link.cs_n),
    .sclk(link.sclk),
    .host_sdio_o(link.host_sdio_o),
    .host_sdio_oe(link.host_sdio_oe),
    .dev_sdio_o(link.dev_sdio_o),
    .dev_sdio_oe(link.dev_sdio_oe)
  );
  // ****************************************
  // Clock, wire monitor, timeout
  // ****************************************
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  // Shift the first sixteen wire bits of each frame in the current order
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    ce_seen <= ce;
    sclk_d <= link.sclk;
    if (link.cs_n) begin
      bits <= 0;
    end else if (link.sclk && !sclk_d) begin
      bits <= bits + 1;
      if (bits < 16) begin
        instr_seen <= lsb_mode ? {link.sdio, instr_seen[15:1]} : {instr_seen[14:0], link.sdio};
      end
    end
    if (cycles == 60000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic cmp(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : cmp
  // One frame: hand over the request, feed or collect bytes until idle
  task automatic xfer(input logic rd, input logic [14:0] a, input int n);
    int k;
    int t;
    k = 0;
    t = 0;
    @(negedge mclk_i);
    req_valid = 1'h1;
    req_read = rd;
    req_addr = a;
    req_len = 4'(n - 1);
    wr_data = wb[0];
    @(negedge mclk_i);
    req_valid = 1'h0;
    while (!req_ready && t < 5000) begin
      // A pulse frozen by a low enable is counted only once
      if (wr_take && ce_seen) begin
        k++;
        wr_data = wb[k % 16];
      end
      if (rd_valid && ce_seen) begin
        rb[k % 16] = rd_data;
        k++;
      end
      @(negedge mclk_i);
      t++;
    end
    // A frame that never ends is a mismatch of its own
    if (t >= 5000) begin
      fails++;
      $display("BAD t=%0t frame did not finish", $time);
    end
    cmp(instr_seen, {rd, a});
    cmp(32'(k), 32'(n));
  endtask : xfer
  task automatic put(input logic [14:0] a, input int n, input logic [47:0] v);
    for (int i = 0; i < n; i++) wb[i] = v[8*i+:8];
    xfer(1'h0, a, n);
  endtask : put
  task automatic get(input logic [14:0] a, input int n, input logic [47:0] v);
    xfer(1'h1, a, n);
    for (int i = 0; i < n; i++) cmp(rb[i], v[8*i+:8]);
  endtask : get
  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(negedge mclk_i);
    reset_n_i = 1'h1;
    get(15'h0000, 1, 48'h00);
    cmp(lsb_first, 1'h0);
    $display("test reset done");
    put(15'h0005, 3, 48'hC3B2A1);
    // Freeze both ends in mid-frame; the read must still come back whole
    fork
      get(15'h0005, 3, 48'hC3B2A1);
      begin
        repeat (500) @(negedge mclk_i);
        ce = 1'h0;
        repeat (37) @(negedge mclk_i);
        ce = 1'h1;
      end
    join
    get(15'h0003, 1, 48'hC3);
    $display("test msb done");
    put(15'h0015, 6, 48'h78563412BC9A);
    cmp(tuning_word, 32'h00000000);
    cmp(phase, 32'h00000000);
    get(15'h0013, 1, 48'h00);
    put(15'h0016, 1, 48'h01);
    cmp(tuning_word, 32'h12345678);
    cmp(phase, 32'h00009ABC);
    get(15'h0016, 1, 48'h00);
    $display("test held done");
    put(15'h0000, 1, 48'h40);
    cmp(lsb_first, 1'h1);
    lsb_mode = 1'h1;
    put(15'h0008, 3, 48'h332211);
    get(15'h0008, 3, 48'h332211);
    get(15'h000A, 1, 48'h33);
    put(15'h0000, 1, 48'h00);
    lsb_mode = 1'h0;
    cmp(lsb_first, 1'h0);
    $display("test lsb done");
    put(15'h0040, 1, 48'h5A);
    get(15'h0040, 1, 48'h00);
    get(15'h0005, 1, 48'hA1);
    cmp(busy, 1'h0);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : three_wire_serial_config_port_tb
`default_nettype wire
